/* rtl/drive_calibration_zone_control.sv */
/*
 Calibration scheduling, zone lookup, serial setup and head ports, and the
 16/17 codec data path of the drive. Assumes host command, calibration
 engine, disk controller and read channel logic share core_clk; only the
 write fault sense pin arrives asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "calib_zone_map.svh"
module drive_calibration_zone_control #(
	parameter int MS_CYCLES = `MS_CYCLES,
	parameter int CAL_INTERVAL_MS = `CAL_INTERVAL_MS,
	parameter int CMD_WAIT_CYCLES = `CMD_WAIT_CYCLES,
	parameter int HEADS = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Host command path
	input wire logic cmdReq,
	input wire calib_zone_pkg::host_cmd_type cmd,
	input wire logic cmdDone,
	output logic cmdGrant,
	// Calibration engine
	output logic calStart,
	output logic calAbort,
	output logic calBusy,
	input wire logic calDone,
	// Zone state
	output calib_zone_pkg::zone_setup_type zoneSetup,
	// Serial ports to head preamplifier and read channel
	output logic serClk,
	output logic serData,
	output logic headSerialEnable,
	output logic setupSerialEnable,
	// Write fault
	input wire logic writeFaultSense,
	output logic writeFault,
	// Write data from disk controller, code groups to read channel
	input wire logic wrValid,
	input wire logic [15:0] wrData,
	output logic wrReady,
	output logic codeValid,
	output logic [16:0] codeData,
	input wire logic codeReady,
	// Read code groups from read channel, words to disk controller
	input wire logic rdCodeValid,
	input wire logic [16:0] rdCode,
	output logic rdCodeReady,
	output logic rdValid,
	output logic [15:0] rdData,
	input wire logic rdReady
);
	localparam logic [13:0] ZSTART [`ZONE_COUNT] = `ZONE_START;
	localparam logic [11:0] ZRATE [`ZONE_COUNT] = `ZONE_RATE;
	localparam int HBITS = $clog2(HEADS);

	calib_zone_pkg::cal_state_type state_q;
	logic schedKind_q;
	logic resume_q;
	logic calPending_q;
	logic [31:0] msCnt_q;
	logic [31:0] slotCnt_q;
	logic slotTick;
	logic [31:0] waitCnt_q;
	logic waitLimit;
	logic [13:0] geBound;
	logic [3:0] zoneCalc;
	logic setupPend_q;
	logic headPend_q;
	logic [2:0] head_q;
	logic [31:0] shift_q;
	logic [5:0] bitsLeft_q;
	logic [2:0] halfCnt_q;
	logic faultMeta_q;
	logic accept;
	logic preempt;
	logic idleSer;
	logic shiftLoadHead;
	logic shiftLoadSetup;

	function automatic logic [16:0] encode(input logic [15:0] d);
		logic [15:0] a;
		logic [15:0] b;
		a = d ^ `CODE_MASK_A;
		b = d ^ `CODE_MASK_B;
		// Flag bit in the middle breaks long runs; pick the denser image
		if ($countones(a) >= $countones(b))
			encode = {a[15:8], 1'b1, a[7:0]};
		else
			encode = {b[15:8], 1'b0, b[7:0]};
	endfunction

	function automatic logic [15:0] decode(input logic [16:0] c);
		logic [15:0] v;
		v = {c[16:9], c[7:0]};
		decode = c[8] ? (v ^ `CODE_MASK_A) : (v ^ `CODE_MASK_B);
	endfunction

	// Elapsed time since power-on; never restarted by calibrations
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			msCnt_q <= 32'd0;
			slotCnt_q <= 32'd0;
		end
		else if (msCnt_q == 32'(MS_CYCLES - 1))
		begin
			msCnt_q <= 32'd0;
			slotCnt_q <= slotTick ? 32'd0 : slotCnt_q + 32'd1;
		end
		else
			msCnt_q <= msCnt_q + 32'd1;
	end
	assign slotTick = (msCnt_q == 32'(MS_CYCLES - 1)) &&
		(slotCnt_q == 32'(CAL_INTERVAL_MS - 1));

	// Host wait watchdog while a request is held off
	always_ff @(posedge core_clk)
	begin
		if (rst || !cmdReq || cmdGrant)
			waitCnt_q <= 32'd0;
		else
			waitCnt_q <= waitCnt_q + 32'd1;
	end
	assign waitLimit = (waitCnt_q >= 32'(CMD_WAIT_CYCLES - 2));

	assign accept = cmdReq && !cmdGrant;
	assign preempt = accept && !cmd.recal &&
		(schedKind_q || waitLimit);

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q <= calib_zone_pkg::ST_IDLE;
			schedKind_q <= 1'b0;
			resume_q <= 1'b0;
			cmdGrant <= 1'b0;
			calStart <= 1'b0;
			calAbort <= 1'b0;
			calBusy <= 1'b0;
		end
		else
		begin
			cmdGrant <= 1'b0;
			calStart <= 1'b0;
			calAbort <= 1'b0;
			case (state_q)
			calib_zone_pkg::ST_IDLE:
				if (accept)
				begin
					cmdGrant <= 1'b1;
					if (cmd.recal)
					begin
						calStart <= 1'b1;
						calBusy <= 1'b1;
						schedKind_q <= 1'b0;
						state_q <= calib_zone_pkg::ST_CAL;
					end
					else
						state_q <= calib_zone_pkg::ST_HOST;
				end
				else if (calPending_q)
				begin
					calStart <= 1'b1;
					calBusy <= 1'b1;
					schedKind_q <= 1'b1;
					state_q <= calib_zone_pkg::ST_CAL;
				end
			calib_zone_pkg::ST_CAL:
				if (calDone)
				begin
					calBusy <= 1'b0;
					state_q <= calib_zone_pkg::ST_IDLE;
				end
				else if (accept && cmd.recal)
				begin
					// Restart for the command at once; only the host wait limit can pre-empt it now
					cmdGrant <= 1'b1;
					calStart <= 1'b1;
					calBusy <= 1'b1;
					schedKind_q <= 1'b0;
				end
				else if (preempt)
				begin
					calAbort <= 1'b1;
					calBusy <= 1'b0;
					cmdGrant <= 1'b1;
					resume_q <= schedKind_q;
					state_q <= calib_zone_pkg::ST_HOST;
				end
			calib_zone_pkg::ST_HOST:
				if (cmdDone)
				begin
					if (resume_q || calPending_q)
					begin
						calStart <= 1'b1;
						calBusy <= 1'b1;
						schedKind_q <= 1'b1;
						resume_q <= 1'b0;
						state_q <= calib_zone_pkg::ST_CAL;
					end
					else
						state_q <= calib_zone_pkg::ST_IDLE;
				end
			default:
				state_q <= calib_zone_pkg::ST_IDLE;
			endcase
		end
	end

	// Pending slot: power-on starts set, a new slot wins over the clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
			calPending_q <= 1'b1;
		else if (slotTick)
			calPending_q <= 1'b1;
		else if (calStart && (state_q != calib_zone_pkg::ST_IDLE || !accept))
			calPending_q <= 1'b0;
	end

	// Zone lookup from the cylinder of the granted command
	genvar gi;
	generate
		for (gi = 1; gi < `ZONE_COUNT; gi++)
		begin : g_bound
			assign geBound[gi-1] = (cmd.cyl >= ZSTART[gi]);
		end
	endgenerate
	always_comb
	begin
		zoneCalc = 4'h0;
		for (int i = 0; i < `ZONE_COUNT - 1; i++)
			zoneCalc = zoneCalc + 4'(geBound[i]);
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			zoneSetup <= '{4'h0, ZRATE[0], ZRATE[0][11:4], 8'h00};
			head_q <= 3'h0;
			setupPend_q <= 1'b1;
			headPend_q <= 1'b1;
		end
		else
		begin
			// Clear first, so that a change in the same cycle still gets sent
			if (shiftLoadSetup)
				setupPend_q <= 1'b0;
			if (shiftLoadHead)
				headPend_q <= 1'b0;
			if (accept && cmdGrant == 1'b0 && !cmd.recal &&
				(state_q == calib_zone_pkg::ST_IDLE || preempt))
			begin
				if (zoneCalc != zoneSetup.zone)
				begin
					zoneSetup.zone <= zoneCalc;
					zoneSetup.rate <= ZRATE[zoneCalc];
					zoneSetup.cutoff <= ZRATE[zoneCalc][11:4];
					zoneSetup.boost <= {zoneCalc, 4'h0};
					setupPend_q <= 1'b1;
				end
				if (HBITS'(cmd.head) != HBITS'(head_q))
				begin
					head_q <= 3'(HBITS'(cmd.head));
					headPend_q <= 1'b1;
				end
			end
		end
	end

	// Shared serial shifter: head frame first, then rate/filter setup
	assign idleSer = !headSerialEnable && !setupSerialEnable;
	assign shiftLoadHead = idleSer && headPend_q;
	assign shiftLoadSetup = idleSer && !headPend_q && setupPend_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			shift_q <= 32'h0;
			bitsLeft_q <= 6'd0;
			halfCnt_q <= 3'd0;
			serClk <= 1'b0;
			serData <= 1'b0;
			headSerialEnable <= 1'b0;
			setupSerialEnable <= 1'b0;
		end
		else if (shiftLoadHead)
		begin
			shift_q <= {5'h00, head_q, 24'h000000};
			bitsLeft_q <= 6'(`HEAD_FRAME_BITS);
			halfCnt_q <= 3'd0;
			headSerialEnable <= 1'b1;
		end
		else if (shiftLoadSetup)
		begin
			shift_q <= zoneSetup;
			bitsLeft_q <= 6'(`SETUP_FRAME_BITS);
			halfCnt_q <= 3'd0;
			setupSerialEnable <= 1'b1;
		end
		else if (!idleSer)
		begin
			if (halfCnt_q == 3'(`SER_HALF_CYCLES - 1))
			begin
				halfCnt_q <= 3'd0;
				if (!serClk)
				begin
					if (bitsLeft_q == 6'd0)
					begin
						headSerialEnable <= 1'b0;
						setupSerialEnable <= 1'b0;
					end
					else
					begin
						serData <= shift_q[31];
						shift_q <= {shift_q[30:0], 1'b0};
						bitsLeft_q <= bitsLeft_q - 6'd1;
						serClk <= 1'b1;
					end
				end
				else
					serClk <= 1'b0;
			end
			else
				halfCnt_q <= halfCnt_q + 3'd1;
		end
	end

	// Write fault pin synchroniser
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			faultMeta_q <= 1'b0;
			writeFault <= 1'b0;
		end
		else
		begin
			faultMeta_q <= writeFaultSense;
			writeFault <= faultMeta_q;
		end
	end

	two_entry_buffer #(.WIDTH(17)) wrBuf (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(wrValid),
		.inData(encode(wrData)),
		.inReady(wrReady),
		.outValid(codeValid),
		.outData(codeData),
		.outReady(codeReady)
	);

	two_entry_buffer #(.WIDTH(16)) rdBuf (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(rdCodeValid),
		.inData(decode(rdCode)),
		.inReady(rdCodeReady),
		.outValid(rdValid),
		.outData(rdData),
		.outReady(rdReady)
	);

	property p_power_on;
		@(posedge core_clk) $fell(rst) |-> ##[0:2] calStart;
	endproperty
	a_power_on: assert property (p_power_on)
		else $error("no calibration after power-on");

	property p_recal;
		@(posedge core_clk) disable iff (rst)
		(state_q == calib_zone_pkg::ST_IDLE && accept && cmd.recal)
		|=> calStart && cmdGrant;
	endproperty
	a_recal: assert property (p_recal)
		else $error("recalibrate did not start calibration");

	property p_slot;
		@(posedge core_clk) disable iff (rst) slotTick |=> calPending_q;
	endproperty
	a_slot: assert property (p_slot)
		else $error("periodic slot lost");

	property p_preempt;
		@(posedge core_clk) disable iff (rst)
		(state_q == calib_zone_pkg::ST_CAL && !calDone && accept &&
		!cmd.recal && schedKind_q)
		|=> calAbort && cmdGrant && state_q == calib_zone_pkg::ST_HOST;
	endproperty
	a_preempt: assert property (p_preempt)
		else $error("host command did not pre-empt calibration");

	property p_resume;
		@(posedge core_clk) disable iff (rst)
		(state_q == calib_zone_pkg::ST_HOST && cmdDone && resume_q)
		|=> calStart ##1 state_q == calib_zone_pkg::ST_CAL;
	endproperty
	a_resume: assert property (p_resume)
		else $error("interrupted calibration not resumed");

	property p_wait;
		@(posedge core_clk) disable iff (rst)
		waitCnt_q <= 32'(CMD_WAIT_CYCLES);
	endproperty
	a_wait: assert property (p_wait)
		else $error("host command held off too long");

	property p_frame;
		@(posedge core_clk) disable iff (rst)
		$rose(headSerialEnable) |-> !serClk [*4];
	endproperty
	a_frame: assert property (p_frame)
		else $error("serial clock ran before enable settled");

	property p_codec;
		@(posedge core_clk) disable iff (rst)
		codeValid |-> $countones({codeData[16:9], codeData[7:0]}) >= 8;
	endproperty
	a_codec: assert property (p_codec)
		else $error("code group carries the sparse image");

	property p_rate;
		@(posedge core_clk) disable iff (rst)
		zoneSetup.rate == ZRATE[zoneSetup.zone];
	endproperty
	a_rate: assert property (p_rate)
		else $error("rate does not match zone");
endmodule
`default_nettype wire

/* rtl/calib_zone_map.svh */
/*
 Constants of the calibration scheduler, zone table, serial ports and codec.
 Assumes a 250 MHz core clock; included by the package and the main module.
*/
`ifndef CALIB_ZONE_MAP_SVH
`define CALIB_ZONE_MAP_SVH
`define CORE_CLK_MHZ 250
`define CAL_INTERVAL_MIN 30
`define CMD_WAIT_MS 100
`define MS_CYCLES (1000 * `CORE_CLK_MHZ)
`define CAL_INTERVAL_MS (`CAL_INTERVAL_MIN * 60 * 1000)
`define CMD_WAIT_CYCLES (`CMD_WAIT_MS * `MS_CYCLES)
`define SER_HALF_CYCLES 4
`define HEAD_FRAME_BITS 8
`define SETUP_FRAME_BITS 32
`define ZONE_COUNT 15
`define LAST_CYL 14'd12554
`define ZONE_START '{14'd0, 14'd1309, 14'd2617, 14'd3915, 14'd4869, \
	14'd5649, 14'd6329, 14'd7469, 14'd8249, 14'd8639, 14'd9419, \
	14'd10009, 14'd10599, 14'd11526, 14'd12163}
// Transfer rate per zone in units of 10 kB/s
`define ZONE_RATE '{12'd3467, 12'd3467, 12'd3467, 12'd3357, 12'd3266, \
	12'd3176, 12'd3025, 12'd2918, 12'd2863, 12'd2753, 12'd2662, \
	12'd2570, 12'd2420, 12'd2314, 12'd2147}
`define CODE_MASK_A 16'h5555
`define CODE_MASK_B 16'hAAAA
`endif

/* rtl/calib_zone_pkg.sv */
/*
 Types shared by the calibration and zone control logic.
 Assumes the constant header is on the include path.
*/
`include "calib_zone_map.svh"
package calib_zone_pkg;
	typedef enum {ST_IDLE, ST_CAL, ST_HOST} cal_state_type;
	typedef struct packed {
		logic [3:0] zone;
		logic [11:0] rate;
		logic [7:0] cutoff;
		logic [7:0] boost;
	} zone_setup_type;
	typedef struct packed {
		logic recal;
		logic [13:0] cyl;
		logic [2:0] head;
	} host_cmd_type;
endpackage

/* rtl/two_entry_buffer.sv */
/*
 Two-entry buffer with valid/ready on both sides; all outputs registered.
 Assumes both sides run on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Fill side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Drain side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	logic [WIDTH-1:0] spare_q;
	logic [1:0] count_q;
	logic push;
	logic pop;
	logic [1:0] count_d;

	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	always_comb
	begin
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + 2'd1;
		else if (pop && !push)
			count_d = count_q - 2'd1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			count_q <= 2'd0;
			inReady <= 1'b1;
			outValid <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			inReady <= (count_d != 2'd2);
			outValid <= (count_d != 2'd0);
		end
	end

	// Head entry is the output register; the spare holds a stalled word
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			outData <= '0;
			spare_q <= '0;
		end
		else
		begin
			if (pop)
				outData <= (count_q == 2'd2) ? spare_q : inData;
			else if (push && count_q == 2'd0)
				outData <= inData;
			if (push && (count_q == 2'd2 || (count_q == 2'd1 && !pop)))
				spare_q <= inData;
		end
	end
endmodule
`default_nettype wire

/* sim/calib_partner_model.sv */
/*
 Calibration engine and read channel serial receiver facing the block.
 Assumes the shared core clock; latency comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module calib_partner_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Calibration engine
	input wire logic calStart,
	input wire logic calAbort,
	input wire logic [9:0] calLatency,
	output logic calDone,
	// Serial receiver
	input wire logic serClk,
	input wire logic serData,
	input wire logic headSerialEnable,
	input wire logic setupSerialEnable,
	output logic [31:0] frameBits,
	output logic [5:0] bitCount
);
	logic [9:0] calCnt_q;
	logic serClkPrev_q;
	logic enPrev_q;
	logic en;
	assign en = headSerialEnable | setupSerialEnable;
	// An abort cancels the answer still owed
	always_ff @(posedge core_clk)
	begin
		calDone <= 1'h0;
		if (rst || calAbort)
			calCnt_q <= 10'h000;
		else if (calStart)
			calCnt_q <= calLatency;
		else if (calCnt_q != 10'h000)
		begin
			calCnt_q <= calCnt_q - 10'h001;
			calDone <= (calCnt_q == 10'h001);
		end
	end
	// Shifts on each rising serial clock, first bit ends up highest
	always_ff @(posedge core_clk)
	begin
		serClkPrev_q <= serClk;
		enPrev_q <= en;
		if (en && !enPrev_q)
		begin
			frameBits <= 32'h00000000;
			bitCount <= 6'h00;
		end
		else if (en && serClk && !serClkPrev_q)
		begin
			frameBits <= {frameBits[30:0], serData};
			bitCount <= bitCount + 6'h01;
		end
	end
endmodule
`default_nettype wire

/* sim/test_drive_calibration_zone_control.sv */
/*
 Self-checking bench for the calibration and zone control block.
 Assumes the design files and the partner model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_drive_calibration_zone_control;
	localparam int SLOT = 400;
	localparam int WAITC = 50;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic cmdReq = 1'h0;
	calib_zone_pkg::host_cmd_type cmd = '0;
	logic cmdDone = 1'h0;
	logic writeFaultSense = 1'h0;
	logic wrValid = 1'h0;
	logic [15:0] wrData = 16'h0000;
	logic codeReady = 1'h0;
	logic rdCodeValid = 1'h0;
	logic [16:0] rdCode = 17'h00000;
	logic rdReady = 1'h0;
	logic [9:0] calLatency = 10'h005;
	logic cmdGrant, calStart, calAbort, calBusy, calDone, serClk, serData;
	logic headSerialEnable, setupSerialEnable, writeFault, wrReady;
	logic codeValid, rdCodeReady, rdValid, ab, selSetup, frameEn;
	logic [16:0] codeData;
	logic [15:0] rdData;
	logic [31:0] frameBits;
	logic [5:0] bitCount;
	calib_zone_pkg::zone_setup_type zoneSetup;
	int errorCnt = 0;
	int checkCount = 0;
	int ticks = 0;
	int sinceRel = 0;
	int n, g, t1;
	logic [13:0] zStart [0:15] = '{14'h0000, 14'h051D, 14'h0A39, 14'h0F4B,
		14'h1305, 14'h1611, 14'h18B9, 14'h1D2D, 14'h2039, 14'h21BF,
		14'h24CB, 14'h2719, 14'h2967, 14'h2D06, 14'h2F83, 14'h310B};
	logic [11:0] zRate [0:14] = '{12'hD8B, 12'hD8B, 12'hD8B, 12'hD1D,
		12'hCC2, 12'hC68, 12'hBD1, 12'hB66, 12'hB2F, 12'hAC1, 12'hA66,
		12'hA0A, 12'h974, 12'h90A, 12'h863};
	logic [15:0] wd [0:5] = '{16'h1234, 16'h0001, 16'hFFFE, 16'h8000,
		16'h0F0E, 16'h7FFF};
	logic [16:0] got [0:5];
	logic [16:0] cd [0:5];
	logic [15:0] img;
	assign frameEn = selSetup ? setupSerialEnable : headSerialEnable;
	always #2 core_clk = ~core_clk;
	drive_calibration_zone_control #(.MS_CYCLES(10), .CAL_INTERVAL_MS(40),
		.CMD_WAIT_CYCLES(WAITC), .HEADS(8)) i_drive_calibration_zone_control (
		.core_clk(core_clk), .rst(rst), .cmdReq(cmdReq), .cmd(cmd),
		.cmdDone(cmdDone), .cmdGrant(cmdGrant), .calStart(calStart),
		.calAbort(calAbort), .calBusy(calBusy), .calDone(calDone),
		.zoneSetup(zoneSetup), .serClk(serClk), .serData(serData),
		.headSerialEnable(headSerialEnable),
		.setupSerialEnable(setupSerialEnable),
		.writeFaultSense(writeFaultSense), .writeFault(writeFault),
		.wrValid(wrValid), .wrData(wrData), .wrReady(wrReady),
		.codeValid(codeValid), .codeData(codeData), .codeReady(codeReady),
		.rdCodeValid(rdCodeValid), .rdCode(rdCode),
		.rdCodeReady(rdCodeReady), .rdValid(rdValid), .rdData(rdData),
		.rdReady(rdReady));
	calib_partner_model i_calib_partner_model (.core_clk(core_clk),
		.rst(rst), .calStart(calStart), .calAbort(calAbort),
		.calLatency(calLatency), .calDone(calDone), .serClk(serClk),
		.serData(serData), .headSerialEnable(headSerialEnable),
		.setupSerialEnable(setupSerialEnable), .frameBits(frameBits),
		.bitCount(bitCount));
	task completeRun;
		$display("Comparisons %0d, mismatches %0d", checkCount, errorCnt);
		if (errorCnt == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard far above the expected run length
	always @(posedge core_clk)
	begin
		ticks <= ticks + 1;
		sinceRel <= rst ? 0 : sinceRel + 1;
		if (ticks == 40000)
		begin
			errorCnt++;
			completeRun;
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task wait_start(input int lim);
		n = 0;
		do @(negedge core_clk);
		while (!calStart && ++n < lim);
	endtask
	task host_cmd(input logic r, input logic [13:0] c, input logic [2:0] h);
		@(posedge core_clk);
		cmdReq <= 1'h1;
		cmd <= {r, c, h};
		g = 0;
		do @(negedge core_clk);
		while (!cmdGrant && ++g < 800);
		ab = calAbort;
		check(cmdGrant, 1'h1);
		@(posedge core_clk);
		cmdReq <= 1'h0;
		@(negedge core_clk);
	endtask
	task done_pulse;
		@(posedge core_clk);
		cmdDone <= 1'h1;
		@(posedge core_clk);
		cmdDone <= 1'h0;
	endtask
	task wait_frame(input logic su, input logic [31:0] exp,
		input logic [5:0] bits);
		selSetup = su;
		n = 0;
		do @(negedge core_clk);
		while (!frameEn && ++n < 400);
		do @(negedge core_clk);
		while (frameEn && ++n < 900);
		check(frameBits, exp);
		check(bitCount, bits);
	endtask
	task zone_walk;
		logic [31:0] ex;
		for (int z = 14; z >= 0; z--)
		begin
			ex = {z[3:0], zRate[z], zRate[z][11:4], z[3:0], 4'h0};
			host_cmd(1'h0, zStart[z], z[2:0]);
			check(zoneSetup, ex);
			wait_frame(1'h0, {29'h0, z[2:0]}, 6'h08);
			wait_frame(1'h1, ex, 6'h20);
			done_pulse;
			host_cmd(1'h0, zStart[z + 1] - 14'h0001, z[2:0]);
			check(zoneSetup, ex);
			done_pulse;
		end
	endtask
	task automatic send(input logic rd);
		int s = 0;
		@(posedge core_clk);
		for (int k = 0; k < 6; k++)
		begin
			wrValid <= !rd;
			rdCodeValid <= rd;
			wrData <= wd[k];
			rdCode <= cd[k];
			do @(negedge core_clk);
			while (!(rd ? rdCodeReady : wrReady) && ++s < 300);
			@(posedge core_clk);
		end
		wrValid <= 1'h0;
		rdCodeValid <= 1'h0;
	endtask
	// Receiver stalls every other cycle while draining
	task drain(input logic rd);
		int m;
		m = 0;
		n = 0;
		while (m < 6 && ++n < 300)
		begin
			@(posedge core_clk);
			if (rd)
				rdReady <= ~rdReady;
			else
				codeReady <= ~codeReady;
			@(negedge core_clk);
			if (rd ? rdValid && rdReady : codeValid && codeReady)
			begin
				got[m] = rd ? {1'h0, rdData} : codeData;
				m++;
			end
		end
		check(m, 6);
	endtask
	task codec;
		fork
			send(1'h0);
		join_none
		n = 0;
		do @(negedge core_clk);
		while (wrReady && ++n < 20);
		check(wrReady, 1'h0);
		drain(1'h0);
		wait fork;
		for (int k = 0; k < 6; k++)
		begin
			cd[k] = got[k];
			img = {got[k][16:9], got[k][7:0]};
			check(img ^ (got[k][8] ? 16'h5555 : 16'hAAAA), wd[k]);
			check($countones(img) >= 8, 1'h1);
		end
		fork
			send(1'h1);
		join_none
		drain(1'h1);
		wait fork;
		for (int k = 0; k < 6; k++)
			check(got[k][15:0], wd[k]);
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst <= 1'h0;
		wait_start(3);
		check(calStart, 1'h1);
		check(zoneSetup, 32'h0D8BD800);
		wait_frame(1'h0, 32'h00000000, 6'h08);
		wait_frame(1'h1, 32'h0D8BD800, 6'h20);
		zone_walk;
		repeat (3) @(negedge core_clk);
		n = 0;
		while (calBusy && ++n < 400) @(negedge core_clk);
		wait_start(500);
		t1 = sinceRel;
		check((t1 + 2) % SLOT < 6, 1'h1);
		@(negedge core_clk);
		wait_start(500);
		check(sinceRel - t1, SLOT);
		calLatency <= 10'h12C;
		wait_start(500);
		host_cmd(1'h0, 14'h0000, 3'h0);
		check(ab, 1'h1);
		check(calBusy, 1'h0);
		done_pulse;
		wait_start(3);
		check(calStart, 1'h1);
		host_cmd(1'h1, 14'h0000, 3'h0);
		check(g < 3, 1'h1);
		@(negedge core_clk);
		check(calBusy, 1'h1);
		host_cmd(1'h0, 14'h0000, 3'h0);
		check(g <= WAITC + 3, 1'h1);
		done_pulse;
		codec;
		@(posedge core_clk);
		writeFaultSense <= 1'h1;
		n = 0;
		do @(negedge core_clk);
		while (!writeFault && ++n < 4);
		check(writeFault, 1'h1);
		@(posedge core_clk);
		writeFaultSense <= 1'h0;
		n = 0;
		do @(negedge core_clk);
		while (writeFault && ++n < 4);
		check(writeFault, 1'h0);
		completeRun;
	end
endmodule
`default_nettype wire
